// [hdl/fpp_flash_ctrl.sv]
// Purpose: flash program, erase, commit and protection controller
// Assumes: AHB-Lite single word transfers, array applies pulses
// Notes: erase and mass times are parameters to shorten simulation
//
// Function
// - erase 1-KB pages to all ones
// - programming only clears bits of one word
// - protection per 2-KB block, two bits
// - execute-only blocks serve fetches only
// - timing from reload, safe reset default
// - program-enable zero blocks change only by recovery
// - read-enable zero refuses data reads
// - program on, read off: modify, no reads
// - block program/erase of protected block, flag
// - refused data read returns zeros, flag
// - protection words 0 and 1 reset to ones, words 2 and 3 to zeros; uncommitted reverts
// - erases leave nonvolatile registers untouched
// - commit by key word, address picks target
// - commits only clear bits
// - user words writable once, bit 31
// - commit address decode table
// - recovery: mass erase then restore factory
// - control write needs key, key reads zero
// - operation bits read busy, zero ignored
//
// The AHB-Lite interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`include "fpp_consts.svh"
module fpp_flash_ctrl import fpp_pkg::*; #(
   parameter int ERASE_US = 25000,
   parameter int MASS_US = 250000
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic por_reload,
   input wire logic recover_req,
   output fpp_fl_cmd_t fl_cmd,
   input wire fpp_rd_req_t rd_req,
   input wire logic [31:0] fl_rdata,
   output fpp_rd_rsp_t rd_rsp,
   output logic busy
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   logic acc;
   logic wr_pend_r;
   logic rd_pend_r;
   logic [7:0] reg_a_r;
   logic [31:0] addr_r;
   logic [31:0] data_r;
   logic [7:0] usec_r;
   logic [3:0][31:0] live_re_r;
   logic [3:0][31:0] live_pe_r;
   logic [3:0][31:0] nv_re_r;
   logic [3:0][31:0] nv_pe_r;
   logic [1:0][31:0] live_u_r;
   logic [1:0][31:0] nv_u_r;
   logic [31:0] nv_dbg_r;
   logic [1:0] stat_r;
   logic [31:0] rd_mux;
   logic [31:0] hrdata_r;
   logic hreadyout_r;
   logic hresp_r;
   fpp_state_t st_r;
   logic [3:0] op_r;
   logic recov_r;
   logic busy_r;
   logic [7:0] pre_r;
   logic [17:0] us_cnt_r;
   logic [17:0] dur;
   fpp_fl_cmd_t fl_cmd_r;
   logic tick;
   logic ctrl_wr;
   logic key_ok;
   logic idle;
   logic [3:0] op_req;
   logic pe_hit;
   logic all_pe;
   logic perm;
   logic start;
   logic refuse;
   logic rec_go;
   logic fin;
   logic [127:0] pe_flat;
   logic [127:0] re_flat;
   logic [351:0] nv_flat;

   // ---------------------------------------------------------------
   // bus slave
   // ---------------------------------------------------------------
   assign acc = hsel && htrans[1] && hready;

   // reads take one wait state so a read right after a write sees it
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         reg_a_r <= 8'h00;
         hreadyout_r <= 1'b1;
         hresp_r <= 1'b0;
      end else begin
         wr_pend_r <= acc && hwrite;
         rd_pend_r <= acc && !hwrite;
         hreadyout_r <= !(acc && !hwrite);
         hresp_r <= 1'b0;
         if (acc) begin
            reg_a_r <= haddr[7:0];
         end
      end
   end

   always_comb begin
      rd_mux = 32'h0;
      if (reg_a_r[7:4] == `FPP_OFS_RE_HI) begin
         rd_mux = live_re_r[reg_a_r[3:2]];
      end else if (reg_a_r[7:4] == `FPP_OFS_PE_HI) begin
         rd_mux = live_pe_r[reg_a_r[3:2]];
      end else begin
         case (reg_a_r)
            `FPP_OFS_ADDR: rd_mux = {15'h0, addr_r[`FPP_ADDR_MSB:0]};
            `FPP_OFS_DATA: rd_mux = data_r;
            `FPP_OFS_CTRL: rd_mux = {28'h0, op_r};
            `FPP_OFS_STAT: rd_mux = {30'h0, stat_r};
            `FPP_OFS_USEC: rd_mux = {24'h0, usec_r};
            `FPP_OFS_USER0: rd_mux = live_u_r[0];
            `FPP_OFS_USER1: rd_mux = live_u_r[1];
            `FPP_OFS_DBG: rd_mux = nv_dbg_r;
            default: rd_mux = 32'h0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_r <= 32'h0;
      end else if (rd_pend_r) begin
         hrdata_r <= rd_mux;
      end
   end

   // ---------------------------------------------------------------
   // command decode
   // ---------------------------------------------------------------
   assign ctrl_wr = wr_pend_r && (reg_a_r == `FPP_OFS_CTRL);
   assign key_ok = hwdata[31:16] == `FPP_KEY;
   assign idle = st_r == FPP_IDLE;
   assign pe_flat = live_pe_r;
   assign re_flat = live_re_r;
   assign pe_hit = pe_flat[{1'b0, addr_r[`FPP_BLK_HI:`FPP_BLK_LO]}];
   assign all_pe = &live_pe_r[`FPP_IMPL_HI:0];

   // several bits at once: the lowest one wins, writes of zero do nothing
   always_comb begin
      op_req = 4'h0;
      if (ctrl_wr && key_ok && idle) begin
         if (hwdata[`FPP_B_WRITE]) begin
            op_req[`FPP_B_WRITE] = 1'b1;
         end else if (hwdata[`FPP_B_ERASE]) begin
            op_req[`FPP_B_ERASE] = 1'b1;
         end else if (hwdata[`FPP_B_MASS]) begin
            op_req[`FPP_B_MASS] = 1'b1;
         end else if (hwdata[`FPP_B_COMMIT_BIT]) begin
            op_req[`FPP_B_COMMIT_BIT] = 1'b1;
         end
      end
   end

   always_comb begin
      perm = 1'b1;
      if (op_req[`FPP_B_WRITE] || op_req[`FPP_B_ERASE]) begin
         perm = pe_hit;
      end else if (op_req[`FPP_B_MASS]) begin
         perm = all_pe;
      end
   end

   assign start = |op_req && perm;
   assign refuse = |op_req && !perm;
   // recovery must be held until busy rises
   assign rec_go = recover_req && idle && !(|op_req);
   assign tick = pre_r == 8'h00;
   assign fin = st_r == FPP_FIN;

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_r <= FPP_IDLE;
      end else begin
         unique case (st_r)
            FPP_IDLE: begin
               if (start || rec_go) begin
                  st_r <= FPP_WAIT;
               end
            end
            FPP_WAIT: begin
               if (tick && us_cnt_r == 18'd0) begin
                  st_r <= FPP_FIN;
               end
            end
            FPP_FIN: st_r <= FPP_IDLE;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         op_r <= 4'h0;
         recov_r <= 1'b0;
         busy_r <= 1'b0;
      end else if (start || rec_go) begin
         op_r <= start ? op_req : 4'b0100;
         recov_r <= rec_go;
         busy_r <= 1'b1;
      end else if (fin) begin
         op_r <= 4'h0;
         recov_r <= 1'b0;
         busy_r <= 1'b0;
      end
   end

   // the prescaler restarts at each start so no operation runs short
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         pre_r <= `FPP_USEC_RST;
      end else if (start || rec_go || tick) begin
         pre_r <= usec_r;
      end else begin
         pre_r <= pre_r - 8'h01;
      end
   end

   always_comb begin
      dur = `FPP_PROG_US;
      if (rec_go || op_req[`FPP_B_MASS]) begin
         dur = 18'(MASS_US);
      end else if (op_req[`FPP_B_ERASE]) begin
         dur = 18'(ERASE_US);
      end else if (op_req[`FPP_B_COMMIT_BIT]) begin
         dur = `FPP_COMMIT_BIT_US;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         us_cnt_r <= 18'd0;
      end else if (start || rec_go) begin
         us_cnt_r <= dur;
      end else if (tick && us_cnt_r != 18'd0) begin
         us_cnt_r <= us_cnt_r - 18'd1;
      end
   end

   // one-cycle strobes to the array at the start of an operation
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         fl_cmd_r <= '0;
      end else begin
         fl_cmd_r.prog <= start && op_req[`FPP_B_WRITE];
         fl_cmd_r.erase <= start && op_req[`FPP_B_ERASE];
         fl_cmd_r.mass <= (start && op_req[`FPP_B_MASS]) || rec_go;
         fl_cmd_r.addr <= addr_r[`FPP_ADDR_MSB:0];
         fl_cmd_r.clr_mask <= ~data_r;
      end
   end

   // ---------------------------------------------------------------
   // software registers
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         addr_r <= 32'h0;
         data_r <= 32'h0;
         usec_r <= `FPP_USEC_RST;
      end else if (wr_pend_r) begin
         if (reg_a_r == `FPP_OFS_ADDR) begin
            addr_r <= hwdata;
         end
         if (reg_a_r == `FPP_OFS_DATA) begin
            data_r <= hwdata;
         end
         if (reg_a_r == `FPP_OFS_USEC) begin
            usec_r <= hwdata[7:0];
         end
      end
   end

   // live copies only clear; a power-on reload brings back stored values
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         live_re_r <= `FPP_PROT_RST;
         live_pe_r <= `FPP_PROT_RST;
         live_u_r <= {`FPP_USER_RST, `FPP_USER_RST};
      end else if (por_reload) begin
         live_re_r <= nv_re_r;
         live_pe_r <= nv_pe_r;
         live_u_r <= nv_u_r;
      end else if (wr_pend_r) begin
         if (reg_a_r[7:4] == `FPP_OFS_RE_HI) begin
            live_re_r[reg_a_r[3:2]] <= live_re_r[reg_a_r[3:2]] & hwdata;
         end
         if (reg_a_r[7:4] == `FPP_OFS_PE_HI) begin
            live_pe_r[reg_a_r[3:2]] <= live_pe_r[reg_a_r[3:2]] & hwdata;
         end
         if (reg_a_r == `FPP_OFS_USER0) begin
            live_u_r[0] <= live_u_r[0] & hwdata;
         end
         if (reg_a_r == `FPP_OFS_USER1) begin
            live_u_r[1] <= live_u_r[1] & hwdata;
         end
      end
   end

   // set wins over a same-cycle write-one-to-clear
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         stat_r <= 2'b00;
      end else begin
         stat_r[`FPP_ST_FAULT] <= (stat_r[`FPP_ST_FAULT] &&
            !(wr_pend_r && reg_a_r == `FPP_OFS_STAT && hwdata[`FPP_ST_FAULT])) ||
            refuse || rd_rsp.refused;
         stat_r[`FPP_ST_DONE] <= (stat_r[`FPP_ST_DONE] &&
            !(wr_pend_r && reg_a_r == `FPP_OFS_STAT && hwdata[`FPP_ST_DONE])) || fin;
      end
   end

   // ---------------------------------------------------------------
   // nonvolatile store, untouched by page and mass erase
   // ---------------------------------------------------------------
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         nv_re_r <= `FPP_PROT_RST;
         nv_pe_r <= `FPP_PROT_RST;
         nv_u_r <= {`FPP_USER_RST, `FPP_USER_RST};
         nv_dbg_r <= `FPP_DBG_RST;
      end else if (fin && recov_r) begin
         nv_re_r <= `FPP_PROT_RST;
         nv_pe_r <= `FPP_PROT_RST;
         nv_u_r <= {`FPP_USER_RST, `FPP_USER_RST};
         nv_dbg_r <= `FPP_DBG_RST;
      end else if (fin && op_r[`FPP_B_COMMIT_BIT]) begin
         case (addr_r)
            `FPP_CA_RE0: nv_re_r[0] <= nv_re_r[0] & live_re_r[0];
            `FPP_CA_RE1: nv_re_r[1] <= nv_re_r[1] & live_re_r[1];
            `FPP_CA_RE2: nv_re_r[2] <= nv_re_r[2] & live_re_r[2];
            `FPP_CA_RE3: nv_re_r[3] <= nv_re_r[3] & live_re_r[3];
            `FPP_CA_PE0: nv_pe_r[0] <= nv_pe_r[0] & live_pe_r[0];
            `FPP_CA_PE1: nv_pe_r[1] <= nv_pe_r[1] & live_pe_r[1];
            `FPP_CA_PE2: nv_pe_r[2] <= nv_pe_r[2] & live_pe_r[2];
            `FPP_CA_PE3: nv_pe_r[3] <= nv_pe_r[3] & live_pe_r[3];
            `FPP_CA_U0: begin
               if (nv_u_r[0][`FPP_WO_BIT]) begin
                  nv_u_r[0] <= nv_u_r[0] & live_u_r[0] & ~(32'h1 << `FPP_WO_BIT);
               end
            end
            `FPP_CA_U1: begin
               if (nv_u_r[1][`FPP_WO_BIT]) begin
                  nv_u_r[1] <= nv_u_r[1] & live_u_r[1] & ~(32'h1 << `FPP_WO_BIT);
               end
            end
            `FPP_CA_DBG: begin
               if (nv_dbg_r[`FPP_WO_BIT]) begin
                  nv_dbg_r <= nv_dbg_r & data_r & ~(32'h1 << `FPP_WO_BIT);
               end
            end
            default: begin
            end
         endcase
      end
   end

   assign nv_flat = {nv_re_r, nv_pe_r, nv_u_r, nv_dbg_r};

   // ---------------------------------------------------------------
   // read path and outputs
   // ---------------------------------------------------------------
   fpp_read_gate u_gate (
      .hclk(hclk),
      .hresetn(hresetn),
      .rd_req(rd_req),
      .read_en(re_flat),
      .fl_rdata(fl_rdata),
      .rd_rsp(rd_rsp)
   );

   assign hreadyout = hreadyout_r;
   assign hresp = hresp_r;
   assign hrdata = hrdata_r;
   assign fl_cmd = fl_cmd_r;
   assign busy = busy_r;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_key;
      ctrl_wr && !key_ok && idle && !rec_go |=> st_r == FPP_IDLE && !busy_r;
   endproperty
   a_key: assert property (p_key) else $error("keyless control write acted");

   property p_prot;
      (op_req[`FPP_B_WRITE] || op_req[`FPP_B_ERASE]) && !pe_hit
         |=> !fl_cmd_r.prog && !fl_cmd_r.erase && stat_r[`FPP_ST_FAULT];
   endproperty
   a_prot: assert property (p_prot) else $error("protected block was modified");

   property p_clr;
      fl_cmd_r.prog |-> fl_cmd_r.clr_mask == ~data_r;
   endproperty
   a_clr: assert property (p_clr) else $error("program mask not from data");

   property p_busy;
      start |=> busy_r && st_r == FPP_WAIT ##1 op_r != 4'h0;
   endproperty
   a_busy: assert property (p_busy) else $error("busy bit not shown");

   property p_fin;
      fin |=> !busy_r && op_r == 4'h0 && st_r == FPP_IDLE;
   endproperty
   a_fin: assert property (p_fin) else $error("operation did not clear");

   property p_onlyclr;
      !(fin && recov_r) |=> (nv_flat & ~$past(nv_flat)) == '0;
   endproperty
   a_onlyclr: assert property (p_onlyclr) else $error("stored bit went to one");

   property p_once;
      fin && op_r[`FPP_B_COMMIT_BIT] && addr_r == `FPP_CA_U0 && !nv_u_r[0][`FPP_WO_BIT] |=> $stable(nv_u_r[0]);
   endproperty
   a_once: assert property (p_once) else $error("user word written twice");

   property p_recov;
      rec_go |=> fl_cmd_r.mass && recov_r && nv_flat == $past(nv_flat);
   endproperty
   a_recov: assert property (p_recov) else $error("recovery restored before erase");

endmodule // fpp_flash_ctrl

// [hdl/fpp_consts.svh]
// Purpose: named constants of the flash program and protect controller
// Assumes: included by bare name
// Notes: definitions only
`ifndef FPP_CONSTS_SVH
`define FPP_CONSTS_SVH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define FPP_OFS_ADDR 8'h00
`define FPP_OFS_DATA 8'h04
`define FPP_OFS_CTRL 8'h08
`define FPP_OFS_STAT 8'h0C
`define FPP_OFS_USEC 8'h10
`define FPP_OFS_RE_HI 4'h2
`define FPP_OFS_PE_HI 4'h3
`define FPP_OFS_USER0 8'h40
`define FPP_OFS_USER1 8'h44
`define FPP_OFS_DBG 8'h48

// ---------------------------------------------------------------
// control and status fields
// ---------------------------------------------------------------
`define FPP_KEY 16'hA442
`define FPP_B_WRITE 0
`define FPP_B_ERASE 1
`define FPP_B_MASS 2
`define FPP_B_COMMIT_BIT 3
`define FPP_ST_FAULT 0
`define FPP_ST_DONE 1
`define FPP_WO_BIT 31
`define FPP_ADDR_MSB 16
`define FPP_BLK_HI 16
`define FPP_BLK_LO 11
`define FPP_IMPL_HI 1

// ---------------------------------------------------------------
// reset and factory values
// ---------------------------------------------------------------
`define FPP_USEC_RST 8'h31
`define FPP_USER_RST 32'hFFFFFFFF
`define FPP_DBG_RST 32'hFFFFFFFE
`define FPP_PROT_RST 128'h0000_0000_0000_0000_FFFF_FFFF_FFFF_FFFF

// ---------------------------------------------------------------
// operation times in microseconds
// ---------------------------------------------------------------
`define FPP_PROG_US 18'd50
`define FPP_COMMIT_BIT_US 18'd50

// ---------------------------------------------------------------
// commit target selectors
// ---------------------------------------------------------------
`define FPP_CA_RE0 32'h00000000
`define FPP_CA_RE1 32'h00000002
`define FPP_CA_RE2 32'h00000004
`define FPP_CA_RE3 32'h00000008
`define FPP_CA_PE0 32'h00000001
`define FPP_CA_PE1 32'h00000003
`define FPP_CA_PE2 32'h00000005
`define FPP_CA_PE3 32'h00000007
`define FPP_CA_U0 32'h80000000
`define FPP_CA_U1 32'h80000001
`define FPP_CA_DBG 32'h75100000

`endif

// [hdl/fpp_pkg.sv]
// Purpose: types of the flash program and protect controller
// Assumes: nothing
// Notes: constants live in fpp_consts.svh
package fpp_pkg;

   typedef enum logic [2:0] {
      FPP_IDLE = 3'b001,
      FPP_WAIT = 3'b010,
      FPP_FIN = 3'b100
   } fpp_state_t;

   typedef struct packed {
      logic prog;
      logic erase;
      logic mass;
      logic [16:0] addr;
      logic [31:0] clr_mask;
   } fpp_fl_cmd_t;

   typedef struct packed {
      logic valid;
      logic fetch;
      logic [16:0] addr;
   } fpp_rd_req_t;

   typedef struct packed {
      logic valid;
      logic refused;
      logic [31:0] data;
   } fpp_rd_rsp_t;

endpackage

// [hdl/fpp_read_gate.sv]
// Purpose: read-protection gate on the flash read path
// Assumes: array read data valid in the cycle of the request
// Notes: answer one cycle after the request
`timescale 1ns/10ps
`include "fpp_consts.svh"
module fpp_read_gate import fpp_pkg::*; (
   input wire logic hclk,
   input wire logic hresetn,
   input wire fpp_rd_req_t rd_req,
   input wire logic [127:0] read_en,
   input wire logic [31:0] fl_rdata,
   output fpp_rd_rsp_t rd_rsp
);

   logic deny;

   // data reads of a read-disabled block are refused, fetches pass
   assign deny = rd_req.valid && !rd_req.fetch &&
                 !read_en[{1'b0, rd_req.addr[`FPP_BLK_HI:`FPP_BLK_LO]}];

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rd_rsp <= '0;
      end else begin
         rd_rsp.valid <= rd_req.valid;
         rd_rsp.refused <= deny;
         rd_rsp.data <= deny ? 32'h0 : fl_rdata;
      end
   end

   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_zero_fill;
      deny |=> rd_rsp.refused && rd_rsp.data == 32'h0;
   endproperty
   a_zero_fill: assert property (p_zero_fill) else $error("refused read not zero filled");

   property p_fetch_ok;
      rd_req.valid && rd_req.fetch |=> !rd_rsp.refused && rd_rsp.data == $past(fl_rdata);
   endproperty
   a_fetch_ok: assert property (p_fetch_ok) else $error("fetch was refused");

endmodule // fpp_read_gate

// [test/fpp_flash_array_model.sv]
// Purpose: behavioural flash array beside the controller
// Assumes: commands arrive as one-cycle pulses on fl_cmd
// Notes: starts fully erased; read data is combinational
`timescale 1ns/10ps
module fpp_flash_array_model import fpp_pkg::*; (
   input wire logic hclk,
   input wire fpp_fl_cmd_t fl_cmd,
   input wire logic [16:0] rd_addr,
   output logic [31:0] fl_rdata
);
   logic [31:0] mem [0:32767];
   initial begin
      foreach (mem[i]) mem[i] = 32'hFFFFFFFF;
   end
   // ---------------------------------------------------------------
   // array updates
   // ---------------------------------------------------------------
   always @(posedge hclk) begin
      if (fl_cmd.prog) mem[fl_cmd.addr[16:2]] &= ~fl_cmd.clr_mask;
      if (fl_cmd.erase) begin
         for (int i = 0; i < 256; i++) mem[{fl_cmd.addr[16:10], i[7:0]}] = 32'hFFFFFFFF;
      end
      if (fl_cmd.mass) begin
         foreach (mem[i]) mem[i] = 32'hFFFFFFFF;
      end
   end
   assign fl_rdata = mem[rd_addr[16:2]];
endmodule // fpp_flash_array_model

// [test/test_flash_program_protect_ctrl.sv]
// Purpose: self-checking bench of the flash program and protect controller
// Assumes: usec set to 0 so one cycle per microsecond
// Notes: erase and mass times shortened by parameters
`timescale 1ns/10ps
`include "fpp_consts.svh"
module test_flash_program_protect_ctrl import fpp_pkg::*;;
   logic hclk, hresetn, hwrite, hreadyout, hresp, por_reload, recover_req, busy, rdy_s;
   logic [31:0] haddr, hwdata, hrdata, fl_rdata, rdat_s;
   logic [1:0] htrans;
   fpp_fl_cmd_t fl_cmd;
   fpp_rd_req_t rd_req;
   fpp_rd_rsp_t rd_rsp;
   int fails = 0, comparisons = 0, cycles = 0;
   logic [7:0] ra [17] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38,
      8'h3C, 8'h40, 8'h44, 8'h48, 8'h14};
   logic [31:0] rv [17] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h31, '1, '1, 32'h0, 32'h0, '1, '1, 32'h0, 32'h0, '1,
      '1, 32'hFFFFFFFE, 32'h0};
   fpp_flash_ctrl #(.ERASE_US(20), .MASS_US(30)) i_fpp_flash_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(1'b1),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .por_reload(por_reload), .recover_req(recover_req),
      .fl_cmd(fl_cmd), .rd_req(rd_req), .fl_rdata(fl_rdata), .rd_rsp(rd_rsp), .busy(busy));
   fpp_flash_array_model i_fpp_flash_array_model (.hclk(hclk), .fl_cmd(fl_cmd), .rd_addr(rd_req.addr),
      .fl_rdata(fl_rdata));
   // ---------------------------------------------------------------
   // clock, sampling and watchdog
   // ---------------------------------------------------------------
   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // values at the falling edge are what the next rising edge samples
   always @(negedge hclk) begin
      rdy_s = hreadyout;
      rdat_s = hrdata;
   end
   always @(posedge hclk) begin
      cycles++;
      if (cycles == 20000) begin
         fails++;
         finish_test();
      end
   end
   // ---------------------------------------------------------------
   // tasks
   // ---------------------------------------------------------------
   task automatic finish_test();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
      comparisons++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic xf(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] q);
      haddr <= a;
      hwrite <= w;
      htrans <= 2'b10;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      htrans <= 2'b00;
      hwdata <= d;
      do @(posedge hclk); while (rdy_s !== 1'b1);
      q = rdat_s;
   endtask
   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      logic [31:0] q;
      xf(1'b1, a, d, q);
   endtask
   task automatic rc(input string n, input logic [31:0] a, input logic [31:0] e);
      logic [31:0] q;
      xf(1'b0, a, 32'h0, q);
      chk(n, q, e);
   endtask
   task automatic op(input logic [31:0] a, input logic [31:0] d, input int b, input logic ok);
      logic [31:0] q;
      int n;
      wr(`FPP_OFS_DATA, d);
      wr(`FPP_OFS_ADDR, a);
      wr(`FPP_OFS_CTRL, {`FPP_KEY, 16'h0001 << b});
      rc("ctrl_busy", `FPP_OFS_CTRL, ok ? 32'h1 << b : 32'h0);
      chk("busy_resp", {30'h0, busy, hresp}, {30'h0, ok, 1'b0});
      n = 0;
      do begin
         xf(1'b0, `FPP_OFS_CTRL, 32'h0, q);
         n++;
      end while (q[3:0] !== 4'h0 && n < 300);
      chk("ctrl_done", q, 32'h0);
      xf(1'b0, `FPP_OFS_STAT, 32'h0, q);
      chk("status", q & 32'h3, ok ? 32'h2 : 32'h1);
      wr(`FPP_OFS_STAT, 32'h3);
   endtask
   task automatic rdp(input logic [16:0] a, input logic f, input logic [31:0] e, input logic r);
      rd_req <= '{valid: 1'b1, fetch: f, addr: a};
      @(posedge hclk);
      rd_req.valid <= 1'b0;
      for (int n = 0; n < 4; n++) begin
         @(negedge hclk);
         if (rd_rsp.valid === 1'b1) break;
      end
      chk("rd_data", rd_rsp.data, e);
      chk("rd_refused", {31'h0, rd_rsp.refused}, {31'h0, r});
      @(posedge hclk);
   endtask
   // ---------------------------------------------------------------
   // sequence
   // ---------------------------------------------------------------
   initial begin
      hresetn = 1'b0;
      haddr = 32'h0;
      hwdata = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      por_reload = 1'b0;
      recover_req = 1'b0;
      rd_req = '0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int i = 0; i < 17; i++) rc("reset_value", {24'h0, ra[i]}, rv[i]);
      wr(`FPP_OFS_USEC, 32'h0);
      op(32'h100, 32'h0F0F00FF, 0, 1'b1);
      op(32'h100, 32'hFFFF0F0F, 0, 1'b1);
      rdp(17'h100, 1'b0, 32'h0F0F000F, 1'b0);
      wr(`FPP_OFS_CTRL, 32'h00000001);
      rc("no_key", `FPP_OFS_CTRL, 32'h0);
      op(32'h100, 32'h0, 1, 1'b1);
      rdp(17'h104, 1'b0, 32'hFFFFFFFF, 1'b0);
      wr(8'h30, 32'hFFFFFFFD);
      op(32'h800, 32'h0, 0, 1'b0);
      op(32'h800, 32'h0, 1, 1'b0);
      op(32'h0, 32'h0, 2, 1'b0);
      rdp(17'h800, 1'b0, 32'hFFFFFFFF, 1'b0);
      op(32'h1000, 32'h12345678, 0, 1'b1);
      wr(8'h20, 32'hFFFFFFFB);
      rdp(17'h1000, 1'b0, 32'h0, 1'b1);
      rdp(17'h1000, 1'b1, 32'h12345678, 1'b0);
      rc("read_fault", `FPP_OFS_STAT, 32'h1);
      wr(`FPP_OFS_STAT, 32'h3);
      op(`FPP_CA_RE0, 32'h0, 3, 1'b1);
      wr(8'h40, 32'hFFFF00FF);
      op(`FPP_CA_U0, 32'h0, 3, 1'b1);
      wr(8'h40, 32'hFFFFFF00);
      op(`FPP_CA_U0, 32'h0, 3, 1'b1);
      por_reload <= 1'b1;
      @(posedge hclk);
      por_reload <= 1'b0;
      @(posedge hclk);
      rc("kept_commit", 8'h20, 32'hFFFFFFFB);
      rc("reverted", 8'h30, 32'hFFFFFFFF);
      rc("user_once", 8'h40, 32'h7FFF00FF);
      wr(8'h20, 32'hFFFFFFFF);
      rc("only_clear", 8'h20, 32'hFFFFFFFB);
      op(`FPP_CA_DBG, 32'h7FFFFFF0, 3, 1'b1);
      rc("dbg_commit", `FPP_OFS_DBG, 32'h7FFFFFF0);
      op(`FPP_CA_DBG, 32'h0, 3, 1'b1);
      rc("dbg_once", `FPP_OFS_DBG, 32'h7FFFFFF0);
      op(32'h0, 32'h0, 2, 1'b1);
      rdp(17'h1000, 1'b1, 32'hFFFFFFFF, 1'b0);
      rc("nv_kept", 8'h20, 32'hFFFFFFFB);
      recover_req <= 1'b1;
      for (int n = 0; n < 20 && busy !== 1'b1; n++) @(posedge hclk);
      recover_req <= 1'b0;
      for (int n = 0; n < 500 && busy !== 1'b0; n++) @(posedge hclk);
      @(posedge hclk);
      rc("recovered", `FPP_OFS_DBG, 32'hFFFFFFFE);
      rdp(17'h100, 1'b1, 32'hFFFFFFFF, 1'b0);
      finish_test();
   end
endmodule // test_flash_program_protect_ctrl
